/* File: rtl/eep_encoder_emulation_port.v */
// encoder emulation port: quadrature output from motor position, deprecated input modes
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "eep_regs.vh"
// Overview of operation
// - mode zero: connector is input only, emulated outputs not driven.
// - output modes drive A and B a quarter cycle apart, plus index.
// - mode one: index once per revolution at the index offset.
// - mode two: single index when motor reaches the full offset.
// - full offset is absolute turns plus index offset as fraction.
// - index offset uses 65536 units per revolution, any resolution.
// - full offset is read-only, computed, never writable.
// - mode three accepts quadrature input as position source.
// - mode four accepts step and direction, one count per step.
// - mode five accepts up and down pulses and tracks position.
// - resolution: output counts per revolution, or input counts per revolution.
// - resolution is post-quadrature, every edge of both channels counts.
// - resolution zero produces no position command.
// - index offset adjustable within one turn and retained.
module eep_encoder_emulation_port #(
  parameter POS_W = 32
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  // primary feedback position, turns in the high half, 1/65536 turn below
  input wire [POS_W-1:0] motorPos,
  // emulation connector channels
  input wire emuAIn,
  input wire emuBIn,
  output reg emuAOut,
  output reg emuBOut,
  output reg emuIdxOut,
  output reg emuOe,
  // position command from the input modes
  output reg cmdUp,
  output reg cmdDown,
  output reg [POS_W-1:0] cmdPos
);

  localparam FB = `EEP_FRAC_BITS;
  localparam PW = POS_W + 17;

  // configuration registers
  reg [2:0] mode_reg;
  reg [15:0] res_reg;
  reg [15:0] zoff_reg;
  reg [15:0] turns_reg;
  reg dir_reg;
  // output tracking state
  reg [POS_W-1:0] outCount_reg;
  reg [POS_W-1:0] posPrev_reg;
  reg absDone_reg;
  // input tracking state
  reg [15:0] inFrac_reg;
  reg [POS_W-FB-1:0] inTurns_reg;

  wire outMode;
  wire inMode;
  wire resZero;
  wire [PW-1:0] product;
  wire [POS_W-1:0] target;
  wire [POS_W-1:0] fullOffset;
  wire stepFwd;
  wire stepBack;
  wire [1:0] phase;
  wire idxOnce;
  wire idxAbs;
  wire decUp;
  wire decDown;

  // signed crossing of a threshold between two successive positions
  function crossed;
    input [POS_W-1:0] prevP;
    input [POS_W-1:0] curP;
    input [POS_W-1:0] thr;
    begin
      crossed = ($signed(prevP) < $signed(thr) && $signed(curP) >= $signed(thr)) ||
                ($signed(prevP) >= $signed(thr) && $signed(curP) < $signed(thr));
    end
  endfunction

  // crossing of a point inside one revolution, modulo one turn
  function crossedFrac;
    input [15:0] prevF;
    input [15:0] curF;
    input [15:0] z;
    reg [15:0] delta;
    reg [15:0] toZ;
    begin
      delta = curF - prevF;
      toZ = z - prevF;
      if (delta == 16'h0000) begin
        crossedFrac = 1'b0;
      end else if (!delta[15]) begin
        crossedFrac = (toZ != 16'h0000) && (toZ <= delta);
      end else begin
        crossedFrac = ((16'h0000 - toZ) < (16'h0000 - delta)) || (toZ == 16'h0000);
      end
    end
  endfunction

  // gray sequence of the quadrature phase
  function [1:0] quadGray;
    input [1:0] cnt;
    begin
      quadGray = {cnt[1] ^ cnt[0], cnt[1]};
    end
  endfunction

  assign outMode = (mode_reg == `EEP_MODE_ONCE_REV) || (mode_reg == `EEP_MODE_ABSOLUTE);
  assign inMode = (mode_reg == `EEP_MODE_IN_QUAD) || (mode_reg == `EEP_MODE_IN_STEP) ||
                  (mode_reg == `EEP_MODE_IN_UPDN);
  assign resZero = (res_reg == 16'h0000);

  // emulated count target: position times counts per revolution over 65536
  assign product = $signed({motorPos[POS_W-1], motorPos}) * $signed({1'b0, res_reg});
  assign target = product[POS_W+FB-1:FB];

  // full offset: whole turns above, index offset as the fraction
  assign fullOffset = {turns_reg[POS_W-FB-1:0], zoff_reg};

  assign stepFwd = ($signed(target) > $signed(outCount_reg));
  assign stepBack = ($signed(target) < $signed(outCount_reg));
  assign phase = quadGray(outCount_reg[1:0]);

  assign idxOnce = crossedFrac(posPrev_reg[FB-1:0], motorPos[FB-1:0], zoff_reg);
  assign idxAbs = crossed(posPrev_reg, motorPos, fullOffset);

  // decoder for the deprecated input modes
  eep_input_decoder u_dec (
    .clk(clk),
    .rst(rst),
    .mode(mode_reg),
    .chanA(emuAIn),
    .chanB(emuBIn),
    .countUp(decUp),
    .countDown(decDown)
  );

  // register writes; full offset and status have no write effect
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `EEP_RST_MODE;
      res_reg <= `EEP_RST_RES;
      zoff_reg <= `EEP_RST_ZOFF;
      turns_reg <= `EEP_RST_TURNS;
      dir_reg <= `EEP_RST_DIR;
    end else if (regWr) begin
      case (regAddr)
        `EEP_OFF_MODE: mode_reg <= regWrData[2:0];
        `EEP_OFF_RES: res_reg <= regWrData[15:0];
        `EEP_OFF_ZOFF: zoff_reg <= regWrData[15:0];
        `EEP_OFF_TURNS: turns_reg <= regWrData[15:0];
        `EEP_OFF_DIR: dir_reg <= regWrData[0];
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // read data one cycle after the read strobe, zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `EEP_OFF_MODE: regRdData <= {29'h0, mode_reg};
        `EEP_OFF_RES: regRdData <= {16'h0, res_reg};
        `EEP_OFF_ZOFF: regRdData <= {16'h0, zoff_reg};
        `EEP_OFF_TURNS: regRdData <= {16'h0, turns_reg};
        `EEP_OFF_DIR: regRdData <= {31'h0, dir_reg};
        `EEP_OFF_FULL: regRdData <= fullOffset;
        `EEP_OFF_INPOS: regRdData <= cmdPos;
        `EEP_OFF_STATUS: regRdData <= {28'h0, absDone_reg, emuOe, inMode, resZero};
        default: regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

  // emulated counter follows the target one edge per clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      outCount_reg <= {POS_W{1'b0}};
      posPrev_reg <= {POS_W{1'b0}};
    end else begin
      posPrev_reg <= motorPos;
      if (!outMode || resZero) begin
        outCount_reg <= target; // no burst when output resumes
      end else if (stepFwd) begin
        outCount_reg <= outCount_reg + {{(POS_W-1){1'b0}}, 1'b1};
      end else if (stepBack) begin
        outCount_reg <= outCount_reg - {{(POS_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // pins: quadrature pair, index, and drive enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      emuAOut <= 1'b0;
      emuBOut <= 1'b0;
      emuIdxOut <= 1'b0;
      emuOe <= 1'b0;
      absDone_reg <= 1'b0;
    end else begin
      emuOe <= outMode;
      if (outMode) begin
        // direction swaps which channel leads
        emuAOut <= dir_reg ? phase[0] : phase[1];
        emuBOut <= dir_reg ? phase[1] : phase[0];
      end else begin
        emuAOut <= 1'b0;
        emuBOut <= 1'b0;
      end
      if (mode_reg == `EEP_MODE_ONCE_REV) begin
        emuIdxOut <= idxOnce;
      end else if (mode_reg == `EEP_MODE_ABSOLUTE) begin
        emuIdxOut <= idxAbs && !absDone_reg;
      end else begin
        emuIdxOut <= 1'b0;
      end
      // absolute index fires once until mode or offset is rewritten
      if (regWr && (regAddr == `EEP_OFF_MODE || regAddr == `EEP_OFF_TURNS || regAddr == `EEP_OFF_ZOFF)) begin
        absDone_reg <= 1'b0;
      end else if (mode_reg == `EEP_MODE_ABSOLUTE && idxAbs) begin
        absDone_reg <= 1'b1;
      end
    end
  end

  // input position tracking; a revolution is res counts
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inFrac_reg <= 16'h0000;
      inTurns_reg <= {(POS_W-FB){1'b0}};
      cmdUp <= 1'b0;
      cmdDown <= 1'b0;
      cmdPos <= {POS_W{1'b0}};
    end else begin
      cmdUp <= 1'b0;
      cmdDown <= 1'b0;
      if (inMode && !resZero) begin
        if (decUp) begin
          cmdUp <= 1'b1;
          cmdPos <= cmdPos + {{(POS_W-1){1'b0}}, 1'b1};
          if (inFrac_reg >= res_reg - 16'h0001) begin
            inFrac_reg <= 16'h0000;
            inTurns_reg <= inTurns_reg + {{(POS_W-FB-1){1'b0}}, 1'b1};
          end else begin
            inFrac_reg <= inFrac_reg + 16'h0001;
          end
        end else if (decDown) begin
          cmdDown <= 1'b1;
          cmdPos <= cmdPos - {{(POS_W-1){1'b0}}, 1'b1};
          if (inFrac_reg == 16'h0000) begin
            inFrac_reg <= res_reg - 16'h0001;
            inTurns_reg <= inTurns_reg - {{(POS_W-FB-1){1'b0}}, 1'b1};
          end else begin
            inFrac_reg <= inFrac_reg - 16'h0001;
          end
        end
      end
    end
  end
endmodule

/* File: rtl/eep_input_decoder.v */
// decoder for the input modes: quadrature, step/direction and up/down pulses
`timescale 1ns/1ps
module eep_input_decoder (
  // clock and reset
  input wire clk,
  input wire rst,
  // selected mode
  input wire [2:0] mode,
  // connector channels
  input wire chanA,
  input wire chanB,
  // count pulses
  output reg countUp,
  output reg countDown
);
`include "eep_regs.vh"

  reg aPrev_reg;
  reg bPrev_reg;
  wire aRise;
  wire bRise;
  wire quadChange;
  wire quadFwd;

  assign aRise = chanA & ~aPrev_reg;
  assign bRise = chanB & ~bPrev_reg;
  assign quadChange = (chanA ^ aPrev_reg) | (chanB ^ bPrev_reg);
  // forward when the new A differs from the old B (A leads B)
  assign quadFwd = chanA ^ bPrev_reg;

  // previous channel levels for edge detection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aPrev_reg <= 1'b0;
      bPrev_reg <= 1'b0;
    end else begin
      aPrev_reg <= chanA;
      bPrev_reg <= chanB;
    end
  end

  // count pulses per mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      countUp <= 1'b0;
      countDown <= 1'b0;
    end else begin
      countUp <= 1'b0;
      countDown <= 1'b0;
      case (mode)
        `EEP_MODE_IN_QUAD: begin
          // each edge of one channel alone is one count; both channels changing at once give none
          if (quadChange && !((chanA ^ aPrev_reg) & (chanB ^ bPrev_reg))) begin
            countUp <= quadFwd;
            countDown <= ~quadFwd;
          end
        end
        `EEP_MODE_IN_STEP: begin
          // step on A rising, direction on B
          if (aRise) begin
            countUp <= ~chanB;
            countDown <= chanB;
          end
        end
        `EEP_MODE_IN_UPDN: begin
          // separate up and down pulse lines
          if (aRise != bRise) begin
            countUp <= aRise;
            countDown <= bRise;
          end
        end
        default: begin
          countUp <= 1'b0;
          countDown <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: rtl/eep_regs.vh */
// constants for the encoder emulation port: offsets, field codes, reset values
`ifndef EEP_REGS_VH
`define EEP_REGS_VH
// register byte offsets
`define EEP_OFF_MODE 8'h00
`define EEP_OFF_RES 8'h04
`define EEP_OFF_ZOFF 8'h08
`define EEP_OFF_TURNS 8'h0c
`define EEP_OFF_DIR 8'h10
`define EEP_OFF_FULL 8'h14
`define EEP_OFF_INPOS 8'h18
`define EEP_OFF_STATUS 8'h1c
// emulation mode codes
`define EEP_MODE_INPUT 3'h0
`define EEP_MODE_ONCE_REV 3'h1
`define EEP_MODE_ABSOLUTE 3'h2
`define EEP_MODE_IN_QUAD 3'h3
`define EEP_MODE_IN_STEP 3'h4
`define EEP_MODE_IN_UPDN 3'h5
// reset values
`define EEP_RST_MODE 3'h0
`define EEP_RST_RES 16'h0000
`define EEP_RST_ZOFF 16'h0000
`define EEP_RST_TURNS 16'h0000
`define EEP_RST_DIR 1'h0
// fraction field: one revolution is 65536 units
`define EEP_FRAC_BITS 16
`endif

/* File: testbench/eep_partner.sv */
// far-side controller: drives connector inputs and decodes the emulated pair
`timescale 1ns/1ps
module eep_partner (
  // clock and reset
  input wire clk,
  input wire rst,
  // emulated output
  input wire emuAOut,
  input wire emuBOut,
  // lines into the port
  output reg chanA,
  output reg chanB,
  // decoded count
  output reg signed [31:0] rxCount
);
  reg [1:0] qs;
  reg [1:0] prevIdx;
  wire [1:0] curIdx = {emuBOut, emuAOut ^ emuBOut};
  initial begin
    chanA = 1'b0;
    chanB = 1'b0;
    qs = 2'h0;
  end
  // count quarter steps of the pair, order 00 10 11 01 forward
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prevIdx <= 2'h0;
      rxCount <= 0;
    end else begin
      prevIdx <= curIdx;
      if (curIdx == prevIdx + 2'h1) rxCount <= rxCount + 1;
      else if (curIdx == prevIdx - 2'h1) rxCount <= rxCount - 1;
    end
  end
  // burst of counts in one signal type; gap sets the pace
  task send(input [2:0] kind, input up, input integer n, input integer gap);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        if (kind == 3'h3) begin
          qs = up ? qs + 2'h1 : qs - 2'h1;
          chanA <= qs[1] ^ qs[0];
          chanB <= qs[1];
        end else begin
          chanB <= !up;
          @(posedge clk);
          chanA <= (kind == 3'h4) || up;
          @(posedge clk);
          chanA <= 1'b0;
          chanB <= 1'b0;
        end
        repeat (gap) @(posedge clk);
      end
    end
  endtask
endmodule

/* File: testbench/eep_properties.sv */
// assertions on the encoder emulation port outputs
`timescale 1ns/1ps
module eep_checker #(
  parameter POS_W = 32
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] regAddr,
  input wire regRd,
  input wire [31:0] regRdData,
  // emulated output
  input wire emuAOut,
  input wire emuBOut,
  input wire emuIdxOut,
  input wire emuOe,
  // position command
  input wire cmdUp,
  input wire cmdDown,
  input wire [POS_W-1:0] cmdPos
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // output relations
  property p_off; !emuOe [*2] |-> !emuAOut && !emuBOut && !emuIdxOut; endproperty
  a_off: assert property (p_off) else $error("output active while disabled");
  property p_quad; emuOe && $past(emuOe) |-> !($changed(emuAOut) && $changed(emuBOut)); endproperty
  a_quad: assert property (p_quad) else $error("both channels moved at once");
  property p_idx; emuIdxOut |=> !emuIdxOut; endproperty
  a_idx: assert property (p_idx) else $error("index wider than one clock");
  property p_idx_oe; emuIdxOut |-> emuOe; endproperty
  a_idx_oe: assert property (p_idx_oe) else $error("index while not an output");
  // command relations
  property p_updn; !(cmdUp && cmdDown); endproperty
  a_updn: assert property (p_updn) else $error("up and down together");
  property p_step; $changed(cmdPos) |->
    cmdPos - $past(cmdPos) == 1 || $past(cmdPos) - cmdPos == 1; endproperty
  a_step: assert property (p_step) else $error("command moved by more than one");
  property p_in; cmdUp || cmdDown |-> !emuOe; endproperty
  a_in: assert property (p_in) else $error("command while an output");
  // register port relations
  property p_rd_idle; !regRd |=> regRdData == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_status; regRd && regAddr == 8'h1c |=>
    regRdData[31:4] == 28'h0 && regRdData[2] == $past(emuOe); endproperty
  a_status: assert property (p_status) else $error("status does not match output enable");
  // main scenarios
  c_idx: cover property (emuIdxOut);
  c_up: cover property (cmdUp);
  c_down: cover property (cmdDown);
endmodule

bind eep_encoder_emulation_port eep_checker #(.POS_W(POS_W)) eep_checker_i (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .emuAOut(emuAOut), .emuBOut(emuBOut),
  .emuIdxOut(emuIdxOut), .emuOe(emuOe), .cmdUp(cmdUp), .cmdDown(cmdDown), .cmdPos(cmdPos));

/* File: testbench/tb_top.sv */
// self-checking bench for the encoder emulation port
`timescale 1ns/1ps
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin errorCnt = errorCnt + 1; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] motorPos = 32'h0;
  logic [31:0] d;
  wire [31:0] regRdData, cmdPos;
  wire emuAIn, emuBIn, emuAOut, emuBOut, emuIdxOut, emuOe, cmdUp, cmdDown;
  wire signed [31:0] rxCount;
  integer errorCnt = 0;
  integer checks = 0;
  integer idxCnt = 0;
  integer i;
  // address, write data, read-back
  localparam logic [71:0] ROWS [7] = '{72'h00_ffff_fff5_0000_0005, 72'h04_1234_0800_0000_0800,
    72'h08_0000_8000_0000_8000, 72'h0c_0000_0014_0000_0014, 72'h10_0000_0003_0000_0001,
    72'h14_0000_dead_0014_8000, 72'h20_ffff_ffff_0000_0000};
  always #50 clk = ~clk;
  always @(posedge clk) if (emuIdxOut === 1'b1) idxCnt = idxCnt + 1;
  eep_encoder_emulation_port #(.POS_W(32)) eep_encoder_emulation_port_i (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .motorPos(motorPos), .emuAIn(emuAIn), .emuBIn(emuBIn), .emuAOut(emuAOut), .emuBOut(emuBOut),
    .emuIdxOut(emuIdxOut), .emuOe(emuOe), .cmdUp(cmdUp), .cmdDown(cmdDown), .cmdPos(cmdPos));
  eep_partner eep_partner_i (.clk(clk), .rst(rst), .emuAOut(emuAOut), .emuBOut(emuBOut),
    .chanA(emuAIn), .chanB(emuBIn), .rxCount(rxCount));
  task endSim;
    begin
      $display("comparisons %0d, mismatches %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // register bus cycles
  task wr(input [7:0] a, input [31:0] w);
    begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= w;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
    end
  endtask
  task move(input [31:0] step, input integer n);
    repeat (n) begin
      @(posedge clk);
      motorPos <= motorPos + step;
    end
  endtask
  // bounded wait for the decoded count
  task settle(input integer e);
    integer k;
    begin
      for (k = 0; k < 40 && rxCount !== e; k = k + 1) @(posedge clk);
      if (k == 40) begin
        errorCnt = errorCnt + 1;
        endSim;
      end
      `CHK(rxCount, e)
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      wr(ROWS[i][71:64], ROWS[i][63:32]);
      rd(ROWS[i][71:64]);
      `CHK(d, ROWS[i][31:0])
    end
    // mode one: two turns, index at half a turn
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h4);
    wr(8'h00, 32'h1);
    rd(8'h1c);
    `CHK(d[2:0], 3'h4)
    move(32'h1000, 32);
    settle(8);
    `CHK(idxCnt, 2)
    // reversed direction
    wr(8'h10, 32'h1);
    move(32'h1000, 16);
    settle(4);
    `CHK(idxCnt, 3)
    // mode two: one index at 3.5 turns, none on return
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h2);
    move(32'h1000, 32);
    move(32'hffff_f000, 32);
    settle(4);
    `CHK(idxCnt, 4)
    // mode zero: input only, the setting a configurer should prefer
    wr(8'h00, 32'h0);
    move(32'h1000, 16);
    `CHK({emuOe, emuAOut, emuBOut}, 3'h0)
    settle(4);
    // input modes: five up, two down
    wr(8'h04, 32'h10);
    for (i = 3; i < 6; i = i + 1) begin
      wr(8'h00, i);
      eep_partner_i.send(i[2:0], 1'b1, 5, 0);
      eep_partner_i.send(i[2:0], 1'b0, 2, 3);
      repeat (4) @(posedge clk);
      rd(8'h18);
      `CHK(d, 3 * (i - 2))
    end
    wr(8'h04, 32'h0);
    eep_partner_i.send(3'h5, 1'b1, 3, 1);
    repeat (4) @(posedge clk);
    rd(8'h18);
    `CHK(d, 32'h9)
    // second reset clears settings
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      rd(8'(4 * i));
      `CHK(d, 32'h0)
    end
    endSim;
  end
endmodule
